// ---- hdl/adcf_pkg.sv ----
package adcf_pkg;

  // ==========================================================
  // Register byte offsets
  localparam logic [7:0] OFS_RES_LO  = 8'h00;
  localparam logic [7:0] OFS_RES_HI  = 8'h04;
  localparam logic [7:0] OFS_CTRL    = 8'h08;
  localparam logic [7:0] OFS_SRC_CLK = 8'h0c;
  localparam logic [7:0] OFS_AMP     = 8'h10;
  localparam logic [7:0] OFS_BGAP    = 8'h14;
  localparam logic [7:0] OFS_IRQ_ST  = 8'h18;
  localparam logic [7:0] OFS_IRQ_MSK = 8'h1c;

  // ==========================================================
  // Field positions
  localparam int CTRL_START_BIT = 7;
  localparam int CTRL_BUSY_BIT  = 6;
  localparam int CTRL_EN_BIT    = 5;
  localparam int CTRL_ALIGN_BIT = 4;
  localparam int SRC_INT_LSB    = 4;
  localparam int AMP_EN_BIT     = 7;
  localparam int AMP_IN_BIT     = 4;
  localparam int AMP_REF_LSB    = 2;
  localparam int IRQ_DONE_BIT   = 0;
  localparam int IRQ_REFUSE_BIT = 1;

  // ==========================================================
  // Writable bit masks and reset values
  localparam logic [7:0] CTRL_WMASK = 8'hbf;
  localparam logic [7:0] SRC_WMASK  = 8'hf7;
  localparam logic [7:0] AMP_WMASK  = 8'h9f;
  localparam logic [7:0] BGAP_WMASK = 8'h01;
  localparam logic [7:0] CTRL_RST   = 8'h00;
  localparam logic [7:0] SRC_RST    = 8'h00;
  localparam logic [7:0] AMP_RST    = 8'h00;
  localparam logic [7:0] BGAP_RST   = 8'h00;
  localparam logic [1:0] IRQ_RST    = 2'h0;

  // ==========================================================
  // Converter, routing and bus constants
  localparam int RES_W = 12;
  localparam int DIV_W = 7;
  localparam logic [3:0] EXT_CH_NINE   = 4'h9;
  localparam logic [3:0] EXT_CH_ELEVEN = 4'hb;
  localparam logic [1:0] LVL_SUPPLY = 2'h0;
  localparam logic [1:0] LVL_AMP    = 2'h1;
  localparam logic [1:0] LVL_GROUND = 2'h2;
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic {ST_IDLE, ST_BUSY} adcf_state_t;

endpackage : adcf_pkg

// ---- hdl/adcf_top.sv ----
// Implementation choices: register access over AXI4-Lite and the register offsets.
`timescale 1ns/1ps
// What this block does
// - Every conversion yields a 12-bit result, external or internal source.
// - Internal select and external channel select jointly pick the input.
// - Picking an internal level disconnects the external channel input.
// - Channels nine and eleven go to supply and battery sense nodes.
// - At most one selected signal reaches the converter input at a time; unmapped channel codes route none.
// - Result sits in two read-only bytes, high and low.
// - Alignment 0: high=11..4, low upper=3..0; 1: high low=11..8, low=7..0.
// - Result byte positions without a result bit read zero.
// - While converter is disabled, result registers keep their contents.
// - Three 8-bit control registers configure the converter.
// - Third control register governs the reference amplifier.
// - A single-bit register holds the bandgap reference enable.
// - Only 12 of the 16 result bit positions carry data.
// - Start written high then low sets busy while enabled; busy clears when done.
// - External codes map to channels 0,1,5-8,9,11; others float.
// - Internal codes pick external, supply/1/2/4, amp/1/2/4 or ground.
// - Conversion clock divides system clock by 1 to 128, codes 0-7.
module adcf_top
  import adcf_pkg::*;
#(
  parameter int ADDR_W = 8
) (
  input  wire logic              aclk,
  input  wire logic              aresetn,
  input  wire logic              ce,
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  input  wire logic [ADDR_W-1:0] s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  output logic                   conv_enable,
  output logic                   conv_start,
  output logic                   conv_tick,
  input  wire logic              conv_done,
  input  wire logic [RES_W-1:0]  conv_data,
  output logic                   route_ext_pin,
  output logic [3:0]             route_ext_chan,
  output logic                   route_supply_sense,
  output logic                   route_battery_sense,
  output logic                   route_internal,
  output logic [1:0]             route_level,
  output logic [1:0]             route_div,
  output logic                   amp_enable,
  output logic                   amp_input_sel,
  output logic [1:0]             ref_select,
  output logic [1:0]             amp_gain,
  output logic                   bandgap_enable,
  output logic                   irq
);

  // ==========================================================
  // State
  logic              awready_q, wready_q, bvalid_q;
  logic              aw_have_q, w_have_q;
  logic [ADDR_W-1:0] aw_addr_q;
  logic [31:0]       w_data_q;
  logic [3:0]        w_strb_q;
  logic [1:0]        bresp_q;
  logic              arready_q, rvalid_q;
  logic [31:0]       rdata_q;
  logic [1:0]        rresp_q;
  logic [7:0]        ctrl_q, src_q, amp_q, bgap_q;
  logic [1:0]        irq_st_q, irq_msk_q;
  logic [1:0]        irq_st_d, irq_msk_d;
  logic              irq_q;
  adcf_state_t       state_q;
  logic [RES_W-1:0]  result_q;
  logic              start_q, tick_q;
  logic [DIV_W-1:0]  div_cnt_q;
  logic              r_ext_q, r_sup_q, r_bat_q, r_int_q;
  logic [3:0]        r_chan_q;
  logic [1:0]        r_lvl_q, r_div_q;

  // ==========================================================
  // Write channel handshake
  logic do_wr, aw_fire, w_fire, wr_lane0;
  logic [ADDR_W-1:0] wa;
  logic [7:0] wd;
  assign aw_fire  = ce & s_axi_awvalid & awready_q;
  assign w_fire   = ce & s_axi_wvalid & wready_q;
  assign do_wr    = ce & aw_have_q & w_have_q & ~bvalid_q;
  assign wa       = aw_addr_q;
  assign wd       = w_data_q[7:0];
  assign wr_lane0 = do_wr & w_strb_q[0];

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_q <= 1'b0;
      awready_q <= 1'b0;
      aw_addr_q <= '0;
    end else if (ce) begin
      if (aw_fire) begin
        aw_have_q <= 1'b1;
        awready_q <= 1'b0;
        aw_addr_q <= s_axi_awaddr;
      end else if (do_wr || !aw_have_q) begin
        aw_have_q <= 1'b0;
        awready_q <= 1'b1;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_have_q <= 1'b0;
      wready_q <= 1'b0;
      w_data_q <= '0;
      w_strb_q <= '0;
    end else if (ce) begin
      if (w_fire) begin
        w_have_q <= 1'b1;
        wready_q <= 1'b0;
        w_data_q <= s_axi_wdata;
        w_strb_q <= s_axi_wstrb;
      end else if (do_wr || !w_have_q) begin
        w_have_q <= 1'b0;
        wready_q <= 1'b1;
      end
    end
  end

  logic wr_mapped;
  always_comb begin
    if (wa == ADDR_W'(OFS_RES_LO) || wa == ADDR_W'(OFS_RES_HI)) begin
      wr_mapped = 1'b1;
    end else if (wa == ADDR_W'(OFS_CTRL) || wa == ADDR_W'(OFS_SRC_CLK)) begin
      wr_mapped = 1'b1;
    end else if (wa == ADDR_W'(OFS_AMP) || wa == ADDR_W'(OFS_BGAP)) begin
      wr_mapped = 1'b1;
    end else if (wa == ADDR_W'(OFS_IRQ_ST) || wa == ADDR_W'(OFS_IRQ_MSK)) begin
      wr_mapped = 1'b1;
    end else begin
      wr_mapped = 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_q <= 1'b0;
      bresp_q  <= RESP_OKAY;
    end else if (ce) begin
      if (do_wr) begin
        bvalid_q <= 1'b1;
        bresp_q  <= wr_mapped ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bready) begin
        bvalid_q <= 1'b0;
      end
    end
  end

  // ==========================================================
  // Control registers; result offsets accept writes but store nothing
  logic wr_ctrl, start_fall;
  assign wr_ctrl    = wr_lane0 & (wa == ADDR_W'(OFS_CTRL));
  // Conversion begins on the high-to-low write of the start bit
  assign start_fall = wr_ctrl & ctrl_q[CTRL_START_BIT]
                    & ~wd[CTRL_START_BIT];

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_q <= CTRL_RST;
      src_q  <= SRC_RST;
      amp_q  <= AMP_RST;
      bgap_q <= BGAP_RST;
    end else if (ce) begin
      if (wr_ctrl) begin
        ctrl_q <= wd & CTRL_WMASK;
      end
      if (wr_lane0 && wa == ADDR_W'(OFS_SRC_CLK)) begin
        src_q <= wd & SRC_WMASK;
      end
      if (wr_lane0 && wa == ADDR_W'(OFS_AMP)) begin
        amp_q <= wd & AMP_WMASK;
      end
      if (wr_lane0 && wa == ADDR_W'(OFS_BGAP)) begin
        bgap_q <= wd & BGAP_WMASK;
      end
    end
  end

  // ==========================================================
  // Conversion sequencer
  logic en, busy, finish, refuse;
  assign en     = ctrl_q[CTRL_EN_BIT];
  assign busy   = (state_q == ST_BUSY);
  assign finish = ce & busy & en & conv_done;
  // A start while disabled or busy is dropped and flagged
  assign refuse = ce & start_fall & (~en | busy);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_q <= ST_IDLE;
      start_q <= 1'b0;
    end else if (ce) begin
      start_q <= 1'b0;
      case (state_q)
        ST_IDLE: begin
          if (start_fall && en) begin
            state_q <= ST_BUSY;
            start_q <= 1'b1;
          end
        end
        ST_BUSY: begin
          // Disabling aborts; the old result stays
          if (!en || conv_done) begin
            state_q <= ST_IDLE;
          end
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  // Raw word is stored once; alignment is applied on read,
  // so both bytes always come from one conversion
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      result_q <= '0;
    end else if (finish) begin
      result_q <= conv_data;
    end
  end

  // ==========================================================
  // Conversion clock divider
  logic [DIV_W-1:0] div_lim;
  assign div_lim = DIV_W'((8'h01 << src_q[2:0]) - 8'h01);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      div_cnt_q <= '0;
      tick_q    <= 1'b0;
    end else if (ce) begin
      if (!en || div_cnt_q >= div_lim) begin
        div_cnt_q <= '0;
      end else begin
        div_cnt_q <= div_cnt_q + DIV_W'(1);
      end
      tick_q <= en & (div_cnt_q >= div_lim);
    end
  end

  // ==========================================================
  // Input routing
  logic [3:0] isel, csel;
  logic       int_pick, pin_ok;
  logic [1:0] lvl, dv;
  assign isel = src_q[SRC_INT_LSB +: 4];
  assign csel = ctrl_q[3:0];

  always_comb begin
    int_pick = 1'b1;
    lvl      = LVL_GROUND;
    dv       = isel[1:0] - 2'h1;
    if (isel[3:2] == 2'b00 && isel[1:0] != 2'b00) begin
      lvl = LVL_SUPPLY;
    end else if (isel[3:2] == 2'b01 && isel[1:0] != 2'b00) begin
      lvl = LVL_AMP;
    end else if (isel[3:2] == 2'b10) begin
      dv = 2'h0;
    end else begin
      int_pick = 1'b0;
      dv       = 2'h0;
    end
  end

  always_comb begin
    if (csel <= 4'h1) begin
      pin_ok = 1'b1;
    end else if (csel >= 4'h5 && csel <= 4'h8) begin
      pin_ok = 1'b1;
    end else begin
      pin_ok = 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      r_ext_q  <= 1'b0;
      r_sup_q  <= 1'b0;
      r_bat_q  <= 1'b0;
      r_int_q  <= 1'b0;
      r_chan_q <= '0;
      r_lvl_q  <= '0;
      r_div_q  <= '0;
    end else if (ce) begin
      r_int_q  <= int_pick;
      r_lvl_q  <= lvl;
      r_div_q  <= dv;
      r_chan_q <= csel;
      r_ext_q  <= ~int_pick & pin_ok;
      r_sup_q  <= ~int_pick & (csel == EXT_CH_NINE);
      r_bat_q  <= ~int_pick & (csel == EXT_CH_ELEVEN);
    end
  end

  // ==========================================================
  // Interrupt status and mask
  logic w1c_hit, msk_hit;
  assign w1c_hit = wr_lane0 & (wa == ADDR_W'(OFS_IRQ_ST));
  assign msk_hit = wr_lane0 & (wa == ADDR_W'(OFS_IRQ_MSK));

  always_comb begin
    irq_st_d  = irq_st_q;
    irq_msk_d = irq_msk_q;
    if (w1c_hit) begin
      irq_st_d = irq_st_q & ~wd[1:0];
    end
    if (msk_hit) begin
      irq_msk_d = wd[1:0];
    end
    // Set applied after clear so a same-cycle event is kept
    if (finish) begin
      irq_st_d[IRQ_DONE_BIT] = 1'b1;
    end
    if (refuse) begin
      irq_st_d[IRQ_REFUSE_BIT] = 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_st_q  <= IRQ_RST;
      irq_msk_q <= IRQ_RST;
      irq_q     <= 1'b0;
    end else if (ce) begin
      irq_st_q  <= irq_st_d;
      irq_msk_q <= irq_msk_d;
      irq_q     <= |(irq_st_d & irq_msk_d);
    end
  end

  // ==========================================================
  // Read channel
  logic ar_fire;
  logic [7:0] rd_byte;
  logic rd_ok;
  assign ar_fire = ce & s_axi_arvalid & arready_q;

  always_comb begin
    rd_byte = 8'h00;
    rd_ok   = 1'b1;
    if (s_axi_araddr == ADDR_W'(OFS_RES_LO)) begin
      rd_byte = ctrl_q[CTRL_ALIGN_BIT] ? result_q[7:0]
                                       : {result_q[3:0], 4'h0};
    end else if (s_axi_araddr == ADDR_W'(OFS_RES_HI)) begin
      rd_byte = ctrl_q[CTRL_ALIGN_BIT] ? {4'h0, result_q[11:8]}
                                       : result_q[11:4];
    end else if (s_axi_araddr == ADDR_W'(OFS_CTRL)) begin
      rd_byte = ctrl_q;
      rd_byte[CTRL_BUSY_BIT] = busy;
    end else if (s_axi_araddr == ADDR_W'(OFS_SRC_CLK)) begin
      rd_byte = src_q;
    end else if (s_axi_araddr == ADDR_W'(OFS_AMP)) begin
      rd_byte = amp_q;
    end else if (s_axi_araddr == ADDR_W'(OFS_BGAP)) begin
      rd_byte = bgap_q;
    end else if (s_axi_araddr == ADDR_W'(OFS_IRQ_ST)) begin
      rd_byte = {6'h00, irq_st_q};
    end else if (s_axi_araddr == ADDR_W'(OFS_IRQ_MSK)) begin
      rd_byte = {6'h00, irq_msk_q};
    end else begin
      rd_ok = 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_q <= 1'b0;
      rvalid_q  <= 1'b0;
      rdata_q   <= '0;
      rresp_q   <= RESP_OKAY;
    end else if (ce) begin
      if (ar_fire) begin
        arready_q <= 1'b0;
        rvalid_q  <= 1'b1;
        rdata_q   <= {24'h000000, rd_byte};
        rresp_q   <= rd_ok ? RESP_OKAY : RESP_SLVERR;
      end else if (rvalid_q && s_axi_rready) begin
        rvalid_q  <= 1'b0;
        arready_q <= 1'b1;
      end else if (!rvalid_q) begin
        arready_q <= 1'b1;
      end
    end
  end

  // ==========================================================
  // Outputs
  assign s_axi_awready       = awready_q;
  assign s_axi_wready        = wready_q;
  assign s_axi_bvalid        = bvalid_q;
  assign s_axi_bresp         = bresp_q;
  assign s_axi_arready       = arready_q;
  assign s_axi_rvalid        = rvalid_q;
  assign s_axi_rdata         = rdata_q;
  assign s_axi_rresp         = rresp_q;
  assign conv_enable         = ctrl_q[CTRL_EN_BIT];
  assign conv_start          = start_q;
  assign conv_tick           = tick_q;
  assign route_ext_pin       = r_ext_q;
  assign route_ext_chan      = r_chan_q;
  assign route_supply_sense  = r_sup_q;
  assign route_battery_sense = r_bat_q;
  assign route_internal      = r_int_q;
  assign route_level         = r_lvl_q;
  assign route_div           = r_div_q;
  assign amp_enable          = amp_q[AMP_EN_BIT];
  assign amp_input_sel       = amp_q[AMP_IN_BIT];
  assign ref_select          = amp_q[AMP_REF_LSB +: 2];
  assign amp_gain            = amp_q[1:0];
  assign bandgap_enable      = bgap_q[0];
  assign irq                 = irq_q;

  // ==========================================================
  // Assertions
  a_start_busy: assert property (@(posedge aclk) disable iff (!aresetn)
    start_fall && en && !busy && ce |=> busy && conv_start)
    else $error("start did not raise busy");

  a_result_done: assert property (@(posedge aclk) disable iff (!aresetn)
    finish |=> !busy && result_q == $past(conv_data))
    else $error("result not loaded as busy cleared");

  a_hold_off: assert property (@(posedge aclk) disable iff (!aresetn)
    !en |=> $stable(result_q))
    else $error("result changed while disabled");

  a_low_align0: assert property (@(posedge aclk) disable iff (!aresetn)
    ar_fire && s_axi_araddr == ADDR_W'(OFS_RES_LO)
    && !ctrl_q[CTRL_ALIGN_BIT]
    |=> rdata_q[7:0] == {$past(result_q[3:0]), 4'h0})
    else $error("low byte wrong for alignment 0");

  a_high_align1: assert property (@(posedge aclk) disable iff (!aresetn)
    ar_fire && s_axi_araddr == ADDR_W'(OFS_RES_HI)
    && ctrl_q[CTRL_ALIGN_BIT]
    |=> rdata_q[7:0] == {4'h0, $past(result_q[11:8])})
    else $error("high byte wrong for alignment 1");

  a_upper_zero: assert property (@(posedge aclk) disable iff (!aresetn)
    rvalid_q |-> rdata_q[31:8] == 24'h000000)
    else $error("bits above the byte not zero");

  a_ext_off: assert property (@(posedge aclk) disable iff (!aresetn)
    r_int_q |-> !r_ext_q && !r_sup_q && !r_bat_q)
    else $error("external input left on with internal pick");

  a_one_source: assert property (@(posedge aclk) disable iff (!aresetn)
    $onehot0({r_int_q, r_ext_q, r_sup_q, r_bat_q}))
    else $error("more than one source routed");

  a_nine_route: assert property (@(posedge aclk) disable iff (!aresetn)
    ce && !int_pick && csel == EXT_CH_NINE |=> r_sup_q)
    else $error("channel nine not on supply sense");

  a_div_one: assert property (@(posedge aclk) disable iff (!aresetn)
    ce && en && src_q[2:0] == 3'h0 |=> tick_q)
    else $error("divide by one does not tick");

  c_conversion: cover property (@(posedge aclk) disable iff (!aresetn)
    start_fall ##[1:60] finish);
  c_refused: cover property (@(posedge aclk) disable iff (!aresetn)
    refuse);
  c_irq: cover property (@(posedge aclk) disable iff (!aresetn)
    $rose(irq_q));

endmodule : adcf_top

// ---- test/adcf_core_model.sv ----
`timescale 1ns/1ps
module adcf_core_model
  import adcf_pkg::*;
#(
  parameter int DELAY = 20
) (
  input  wire logic             aclk,
  input  wire logic             conv_start,
  input  wire logic             conv_enable,
  input  wire logic [RES_W-1:0] sample,
  output logic                  conv_done,
  output logic [RES_W-1:0]      conv_data
);
  // ==========================================================
  // Analog core stand-in
  int   cnt_q;
  logic run_q;
  initial begin
    run_q     = 1'b0;
    cnt_q     = 0;
    conv_done = 1'b0;
    conv_data = 12'h000;
  end
  // Data is garbage outside the done cycle so a late sampler is caught
  always @(posedge aclk) begin
    conv_done <= 1'b0;
    conv_data <= ~conv_data;
    if (!conv_enable) begin
      run_q <= 1'b0;
    end else if (conv_start) begin
      run_q <= 1'b1;
      cnt_q <= DELAY;
    end else if (run_q && cnt_q == 0) begin
      run_q     <= 1'b0;
      conv_done <= 1'b1;
      conv_data <= sample;
    end else if (run_q) begin
      cnt_q <= cnt_q - 1;
    end
  end
endmodule : adcf_core_model

// ---- test/tb.sv ----
`timescale 1ns/1ps
module tb;
  import adcf_pkg::*;
  logic             aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
  logic [7:0]       awaddr, araddr;
  logic [31:0]      wdata, rdata, rd;
  logic [3:0]       wstrb;
  logic             awready, wready, bvalid, arready, rvalid;
  logic [1:0]       bresp, rresp, rsp, r_lvl, r_div, ref_sel, gain;
  logic             c_en, c_start, c_tick, c_done;
  logic [RES_W-1:0] c_data, sample;
  logic             r_pin, r_sup, r_bat, r_int, amp_en, amp_in, bg_en, irq;
  logic [3:0]       r_ch;
  logic             ie, ce;
  int               fails, checks, cyc, n;
  logic [31:0]      rows [6] = '{32'h0abc_abc0, 32'h1abc_0abc, 32'h0fff_fff0,
                                 32'h1fff_0fff, 32'h05a5_5a50, 32'h1001_0001};
  adcf_top dut (.aclk(aclk), .aresetn(aresetn), .ce(ce),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .conv_enable(c_en),
    .conv_start(c_start), .conv_tick(c_tick), .conv_done(c_done),
    .conv_data(c_data), .route_ext_pin(r_pin), .route_ext_chan(r_ch),
    .route_supply_sense(r_sup), .route_battery_sense(r_bat),
    .route_internal(r_int), .route_level(r_lvl), .route_div(r_div),
    .amp_enable(amp_en), .amp_input_sel(amp_in), .ref_select(ref_sel),
    .amp_gain(gain), .bandgap_enable(bg_en), .irq(irq));
  adcf_core_model model (.aclk(aclk), .conv_start(c_start),
    .conv_enable(c_en), .sample(sample), .conv_done(c_done),
    .conv_data(c_data));
  // ==========================================================
  // Clock, timeout and reporting
  initial begin
    aclk = 1'b0;
    forever #20 aclk = ~aclk;
  end
  task automatic close_out;
    $display("checks=%0d fails=%0d", checks, fails);
    if (fails == 0 && checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : close_out
  always @(posedge aclk) begin
    cyc++;
    if (cyc == 30000) begin
      fails++;
      close_out();
    end
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      fails++;
      $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  // ==========================================================
  // Bus master: payload held until each channel's own ready edge
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge aclk);
    awaddr  <= a;
    awvalid <= 1'b1;
    wdata   <= {24'h0, d};
    wstrb   <= 4'h1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    rsp = bresp;
    bready <= 1'b0;
  endtask : wr
  task automatic rd_reg(input logic [7:0] a);
    @(posedge aclk);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    do begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    rd  = rdata;
    rsp = rresp;
    rready <= 1'b0;
  endtask : rd_reg
  // Route outputs lag the register write by a cycle
  task automatic settle;
    repeat (2) @(posedge aclk);
    #1;
  endtask : settle
  // ==========================================================
  // Main sequence
  initial begin
    {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
    {awaddr, araddr, wdata, wstrb} = '0;
    sample  = 12'h000;
    ce      = 1'b1;
    aresetn = 1'b0;
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    for (int i = 0; i < 6; i++) begin
      sample <= rows[i][27:16];
      wr(OFS_CTRL, 8'ha0 | {3'h0, rows[i][28], 4'h0});
      wr(OFS_CTRL, 8'h20 | {3'h0, rows[i][28], 4'h0});
      rd_reg(OFS_CTRL);
      chk(rd & 32'h40, 32'h40);
      n = 0;
      do begin
        rd_reg(OFS_CTRL);
        n++;
      end while (rd[6] !== 1'b0 && n < 40);
      chk(rd & 32'h40, 32'h0);
      rd_reg(OFS_RES_HI);
      chk(rd, {24'h0, rows[i][15:8]});
      rd_reg(OFS_RES_LO);
      chk(rd, {24'h0, rows[i][7:0]});
      rd_reg(OFS_IRQ_ST);
      chk(rd, 32'h1);
      wr(OFS_IRQ_ST, 8'h01);
    end
    // Start while disabled: refused, result kept, interrupt raised
    wr(OFS_IRQ_MSK, 8'h03);
    wr(OFS_CTRL, 8'h90);
    wr(OFS_CTRL, 8'h10);
    sample <= 12'h123;
    settle();
    chk(irq, 1'b1);
    rd_reg(OFS_IRQ_ST);
    chk(rd, 32'h2);
    // Disabling mid-conversion aborts it: no new result, no done flag
    wr(OFS_CTRL, 8'hb0);
    wr(OFS_CTRL, 8'h30);
    wr(OFS_CTRL, 8'h10);
    rd_reg(OFS_CTRL);
    chk(rd, 32'h10);
    rd_reg(OFS_IRQ_ST);
    chk(rd, 32'h2);
    rd_reg(OFS_RES_LO);
    chk(rd, 32'h01);
    wr(OFS_IRQ_ST, 8'h03);
    settle();
    chk(irq, 1'b0);
    // Unmapped and read-only places
    wr(8'h20, 8'hff);
    chk(rsp, RESP_SLVERR);
    rd_reg(8'h20);
    chk(rd, 32'h0);
    chk(rsp, RESP_SLVERR);
    wr(OFS_RES_HI, 8'hff);
    chk(rsp, RESP_OKAY);
    rd_reg(OFS_RES_HI);
    chk(rd, 32'h0);
    wr(OFS_AMP, 8'hff);
    rd_reg(OFS_AMP);
    chk(rd, 32'h9f);
    wr(OFS_BGAP, 8'hff);
    rd_reg(OFS_BGAP);
    chk(rd, 32'h01);
    wr(OFS_SRC_CLK, 8'hff);
    rd_reg(OFS_SRC_CLK);
    chk(rd, 32'hf7);
    settle();
    chk({amp_en, amp_in, ref_sel, gain, bg_en}, 7'h7f);
    // Internal source codes with an ordinary pin channel selected
    wr(OFS_CTRL, 8'h05);
    for (int s = 0; s < 16; s++) begin
      wr(OFS_SRC_CLK, {s[3:0], 4'h0});
      settle();
      ie = (s inside {[1:3], [5:11]});
      chk({r_int, r_pin}, {ie, !ie});
      if (ie)
        chk(r_lvl, s[3] ? LVL_GROUND
                        : (s[2] ? LVL_AMP : LVL_SUPPLY));
      if (ie && !s[3]) chk(r_div, s[1:0] - 2'h1);
      chk($onehot0({r_pin, r_sup, r_bat, r_int}), 1'b1);
    end
    // External channel codes with the external source picked
    wr(OFS_SRC_CLK, 8'h00);
    for (int c = 0; c < 16; c++) begin
      wr(OFS_CTRL, {4'h0, c[3:0]});
      settle();
      chk({r_pin, r_sup, r_bat, r_int}, {c inside {0, 1, [5:8]}, c == 9,
                                         c == 11, 1'b0});
      if (r_pin === 1'b1) chk(r_ch, c[3:0]);
      chk($onehot0({r_pin, r_sup, r_bat, r_int}), 1'b1);
    end
    // Divider: 256 cycles hold a whole number of tick periods
    wr(OFS_CTRL, 8'h20);
    for (int k = 0; k < 8; k++) begin
      wr(OFS_SRC_CLK, k[7:0]);
      settle();
      n = 0;
      repeat (256) begin
        @(posedge aclk);
        n += (c_tick === 1'b1);
      end
      chk(n, 256 >> k);
    end
    // Clock enable low freezes the divide-by-two tick where it stands
    wr(OFS_SRC_CLK, 8'h01);
    settle();
    @(posedge aclk);
    ce <= 1'b0;
    @(posedge aclk);
    ie = c_tick;
    repeat (4) begin
      @(posedge aclk);
      chk(c_tick, ie);
    end
    ce <= 1'b1;
    // Mid-run reset clears every register
    @(posedge aclk);
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    for (int a = 0; a < 8; a++) begin
      rd_reg(a[7:0] << 2);
      chk(rd, 32'h0);
    end
    chk({c_en, bg_en, irq}, 3'h0);
    close_out();
  end
endmodule : tb
